// >>> design/route_lut_pkg.sv
package route_lut_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] COMPONENT_LABEL_OFS    = 8'h6C;
   localparam logic [7:0] ROUTE_TABLE_SELECT_OFS = 8'h70;
   localparam logic [7:0] ROUTE_TABLE_EGRESS_OFS = 8'h74;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] COMPONENT_LABEL_RST = 32'h0000_0000;
   localparam logic [7:0]  SELECT_BYTE_RST     = 8'h00;

   // ****************************************************************
   // Field positions (LSB of each byte field)
   // ****************************************************************
   localparam int SELECT_HIGH_LSB = 8;
   localparam int SELECT_LOW_LSB  = 0;
   localparam int EGRESS_LSB      = 0;

   // ****************************************************************
   // Routing table geometry and encodings
   // ****************************************************************
   localparam int         NUM_PORTS     = 8;
   localparam int         TABLE_INDEX_W = 16;
   localparam int         TABLE_DEPTH   = 65536;
   localparam int         PORT_W        = 8;
   localparam logic [7:0] UNMAPPED_PORT = 8'hFF;

   // ****************************************************************
   // AXI response codes
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> design/route_lut_indirect_access.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Operation
// R1: 32-bit RW component label, reset zero
// R2: Table writes update every port simultaneously
// R3: Table reads return port zero entry
// R4: Select bits 16:23 hold ID high byte; the code uses bits 8:15
// R5: Select bits 24:31 hold ID low byte; the code uses bits 0:7
// R6: Egress field sets/returns selected entry port
// R7: Port above port total marks entry unmapped
// R8: Software should write 0xFF for unmapped
// R9: Unmapped entry reads back as 0xFF
// R10: Select value never auto-advances after access
// R11: Index is high:low; reserved bits read zero
module route_lut_indirect_access (
   input  wire logic                                   aclk,
   input  wire logic                                   aresetn,
   input  wire logic                                   clk_en,
   // AXI4-Lite write address
   input  wire logic [route_lut_pkg::ADDR_W-1:0]       s_axi_awaddr,
   input  wire logic                                   s_axi_awvalid,
   output logic                                        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [route_lut_pkg::DATA_W-1:0]       s_axi_wdata,
   input  wire logic [route_lut_pkg::STRB_W-1:0]       s_axi_wstrb,
   input  wire logic                                   s_axi_wvalid,
   output logic                                        s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                                  s_axi_bresp,
   output logic                                        s_axi_bvalid,
   input  wire logic                                   s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [route_lut_pkg::ADDR_W-1:0]       s_axi_araddr,
   input  wire logic                                   s_axi_arvalid,
   output logic                                        s_axi_arready,
   // AXI4-Lite read data
   output logic [route_lut_pkg::DATA_W-1:0]            s_axi_rdata,
   output logic [1:0]                                  s_axi_rresp,
   output logic                                        s_axi_rvalid,
   input  wire logic                                   s_axi_rready,
   // Switch side
   input  wire logic [route_lut_pkg::PORT_W-1:0]       port_total,
   output logic [31:0]                                 component_label_value,
   input  wire logic [route_lut_pkg::NUM_PORTS*16-1:0] lookup_id,
   output logic [route_lut_pkg::NUM_PORTS*8-1:0]       lookup_egress
);
   import route_lut_pkg::*;

   // ****************************************************************
   // Internal signals
   // ****************************************************************

   // Write channel holding slots and decode
   logic [ADDR_W-1:0]        aw_addr;
   logic                     aw_held;
   logic [DATA_W-1:0]        w_data;
   logic [STRB_W-1:0]        w_strb;
   logic                     w_held;
   logic                     do_write;
   logic [ADDR_W-3:0]        wr_word;
   logic                     sel_label;
   logic                     sel_select;
   logic                     sel_egress;
   logic [1:0]               next_bresp;

   // Register contents and table access
   logic [7:0]               select_id_high_byte;
   logic [7:0]               select_id_low_byte;
   logic [TABLE_INDEX_W-1:0] table_index;
   logic [PORT_W-1:0]        egress_value;
   logic                     egress_unmapped;
   logic                     table_we;
   logic [PORT_W-1:0]        table_wdata;
   logic [PORT_W-1:0]        port0_entry;

   // Read path
   logic [ADDR_W-3:0]        rd_word;
   logic                     rd_take;
   logic [DATA_W-1:0]        next_rdata;
   logic [1:0]               next_rresp;

   // ****************************************************************
   // Write channel capture
   // ****************************************************************

   // Ready while the holding slot is free
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready  = ~w_held;
   // Commit once both halves are in and no response is pending
   assign do_write      = clk_en & aw_held & w_held & ~s_axi_bvalid;

   // Hold the write address until committed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (clk_en) begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   // Hold the write data until committed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (clk_en) begin
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Write decode
   // ****************************************************************

   // Word index of the held write, byte lanes dropped
   assign wr_word = aw_addr[ADDR_W-1:2];

   // Register select and response code of the held write
   always_comb begin
      sel_label  = 1'b0;
      sel_select = 1'b0;
      sel_egress = 1'b0;
      next_bresp = RESP_OKAY;
      case (wr_word)
         COMPONENT_LABEL_OFS[7:2]: begin
            sel_label = 1'b1; // [R1]
         end
         ROUTE_TABLE_SELECT_OFS[7:2]: begin
            sel_select = 1'b1;
         end
         ROUTE_TABLE_EGRESS_OFS[7:2]: begin
            sel_egress = 1'b1;
         end
         default: begin
            next_bresp = RESP_SLVERR; // Unmapped, write dropped
         end
      endcase
   end

   // Write response valid, held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
      end else if (clk_en) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Write response code, error for unmapped addresses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bresp <= next_bresp;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Component label with byte enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         component_label_value <= COMPONENT_LABEL_RST; // [R1]
      end else if (do_write && sel_label) begin
         for (int b = 0; b < STRB_W; b++) begin
            if (w_strb[b]) begin
               component_label_value[b*8 +: 8] <= w_data[b*8 +: 8]; // [R1]
            end
         end
      end
   end

   // Select bytes change only on software writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         select_id_high_byte <= SELECT_BYTE_RST; // [R4]
         select_id_low_byte  <= SELECT_BYTE_RST; // [R5]
      end else if (do_write && sel_select) begin // [R10]
         if (w_strb[SELECT_HIGH_LSB/8]) begin
            select_id_high_byte <= w_data[SELECT_HIGH_LSB +: 8]; // [R4]
         end
         if (w_strb[SELECT_LOW_LSB/8]) begin
            select_id_low_byte <= w_data[SELECT_LOW_LSB +: 8]; // [R5]
         end
      end
   end

   // High byte above low byte forms the table index
   assign table_index = {select_id_high_byte, select_id_low_byte}; // [R11]

   // Egress write; out of range values stored as unmapped
   assign egress_value    = w_data[EGRESS_LSB +: 8];
   assign egress_unmapped = egress_value > port_total; // [R7]
   assign table_we        = do_write & sel_egress & w_strb[EGRESS_LSB/8];
   assign table_wdata     = egress_unmapped ? UNMAPPED_PORT // [R9]
                                            : egress_value; // [R6]

   // ****************************************************************
   // Per-port routing tables
   // ****************************************************************

   // One table per port, all written together
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [PORT_W-1:0] routing_table [TABLE_DEPTH];
      logic [PORT_W-1:0] port_egress;

      // Shared write port, contents undefined after reset
      always_ff @(posedge aclk) begin
         if (table_we) begin
            routing_table[table_index] <= table_wdata; // [R2]
         end
      end

      // Fabric lookup, registered
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            port_egress <= UNMAPPED_PORT;
         end else if (clk_en) begin
            port_egress <= routing_table[lookup_id[p*16 +: 16]];
         end
      end

      // One driver per output slice
      assign lookup_egress[p*8 +: 8] = port_egress;
   end

   // Software reads see port zero only
   assign port0_entry = g_port[0].routing_table[table_index]; // [R3] [R9]

   // ****************************************************************
   // Read channel
   // ****************************************************************

   // Accept a read whenever no data is pending
   assign s_axi_arready = ~s_axi_rvalid;

   // Word index of the read and its accept strobe
   assign rd_word = s_axi_araddr[ADDR_W-1:2];
   assign rd_take = clk_en & s_axi_arvalid & ~s_axi_rvalid;

   // Read data mux, reserved bits zero
   always_comb begin
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      case (rd_word)
         COMPONENT_LABEL_OFS[7:2]: begin
            next_rdata = component_label_value; // [R1]
         end
         ROUTE_TABLE_SELECT_OFS[7:2]: begin
            next_rdata[SELECT_HIGH_LSB +: 8] = select_id_high_byte; // [R11]
            next_rdata[SELECT_LOW_LSB +: 8]  = select_id_low_byte;
         end
         ROUTE_TABLE_EGRESS_OFS[7:2]: begin
            next_rdata[EGRESS_LSB +: 8] = port0_entry; // [R3] [R9]
         end
         default: begin
            next_rresp = RESP_SLVERR;
         end
      endcase
   end

   // Read valid, held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
      end else if (clk_en) begin
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Read data and code, captured at accept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

endmodule

// >>> sim/route_lut_checker_sva.sv
`timescale 1ns/1ps
// ******
// Bus and table checks
// ******
module route_lut_checker (
   input wire logic                                   aclk,
   input wire logic                                   aresetn,
   input wire logic                                   clk_en,
   input wire logic                                   s_axi_awvalid,
   input wire logic                                   s_axi_awready,
   input wire logic                                   s_axi_wvalid,
   input wire logic                                   s_axi_wready,
   input wire logic                                   s_axi_bvalid,
   input wire logic [route_lut_pkg::ADDR_W-1:0]       s_axi_araddr,
   input wire logic                                   s_axi_arvalid,
   input wire logic                                   s_axi_arready,
   input wire logic [route_lut_pkg::DATA_W-1:0]       s_axi_rdata,
   input wire logic [1:0]                             s_axi_rresp,
   input wire logic                                   s_axi_rvalid,
   input wire logic [31:0]                            component_label_value,
   input wire logic [route_lut_pkg::NUM_PORTS*16-1:0] lookup_id,
   input wire logic [route_lut_pkg::NUM_PORTS*8-1:0]  lookup_egress
);
   import route_lut_pkg::*;
   logic [7:0] rd_ofs;

   // Offset of the read in flight
   always_ff @(posedge aclk) begin
      if (clk_en && s_axi_arvalid && s_axi_arready) begin
         rd_ofs <= s_axi_araddr;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Label only moves on a write commit
   label_commit_a: assert property (
      $changed(component_label_value) |-> $rose(s_axi_bvalid))
      else $error("label changed without a write");
   label_reset_a: assert property (
      $rose(aresetn) |-> component_label_value == 32'h0)
      else $error("label not cleared by reset");
   // Equal lookups on every port give equal egress
   all_ports_a: assert property (
      $past(clk_en) && $past(lookup_id) ==
      {NUM_PORTS{$past(lookup_id[15:0])}} |->
      lookup_egress == {NUM_PORTS{lookup_egress[7:0]}})
      else $error("ports disagree on one entry");
   read_lat_a: assert property (
      clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_lat_a: assert property (
      clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   // Reserved bits read zero
   egress_zero_a: assert property (
      s_axi_rvalid && rd_ofs == 8'h74 |-> s_axi_rdata[31:8] == 24'h0)
      else $error("egress reserved bits set");
   select_zero_a: assert property (
      s_axi_rvalid && rd_ofs == 8'h70 |-> s_axi_rdata[31:16] == 16'h0)
      else $error("select reserved bits set");
   unmapped_rd_a: assert property (
      s_axi_rvalid && !(rd_ofs inside {8'h6C, 8'h70, 8'h74}) |->
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind route_lut_indirect_access route_lut_checker u_checker (
   .aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .component_label_value, .lookup_id, .lookup_egress
);

// >>> sim/route_lut_indirect_access_test.sv
`timescale 1ns/1ps
// ******
// Register bank bench
// ******
module route_lut_indirect_access_test;
   import route_lut_pkg::*;
   logic         aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [7:0]   port_total = 8'h07, v, e;
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, component_label_value, d;
   logic [3:0]   s_axi_wstrb = 4'hF;
   logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic         s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic [1:0]   b, r;
   logic [127:0] lookup_id = 128'h0007_0006_0005_0004_0003_0002_0001_0000;
   logic [63:0]  lookup_egress;
   logic [15:0]  idx;
   logic [7:0]   vals [5] = '{8'h03, 8'h07, 8'h08, 8'hFE, 8'hFF};
   int           mismatches = 0, total_checks = 0;

   route_lut_indirect_access u_dut (
      .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_total,
      .component_label_value, .lookup_id, .lookup_egress
   );

   always #4 aclk = ~aclk;

   // Compare and count
   task automatic chk(input string n, input logic [63:0] x, y);
      total_checks++;
      if (y !== x) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, x, y);
      end
   endtask

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      logic pa, pw, pb;
      @(posedge aclk);
      {pa, pw, pb} = 3'b111;
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pa | pw | pb) begin
         @(posedge aclk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         if (pb && s_axi_bvalid) b = s_axi_bresp;
         pb = pb && !s_axi_bvalid;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
         s_axi_bready <= pb;
      end
   endtask

   // Read: data taken at the edge where rvalid is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic pa, pr;
      @(posedge aclk);
      {pa, pr} = 2'b11;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (pa | pr) begin
         @(posedge aclk);
         pa = pa && !s_axi_arready;
         if (pr && s_axi_rvalid) begin
            q = s_axi_rdata;
            r = s_axi_rresp;
         end
         pr = pr && !s_axi_rvalid;
         s_axi_arvalid <= pa;
         s_axi_rready <= pr;
      end
   endtask

   // Read and compare data together with the response code
   task automatic rc(input string n, input logic [7:0] a,
                     input logic [31:0] x);
      logic [31:0] q;
      rd(a, q);
      chk(n, {RESP_OKAY, x}, {r, q});
   endtask

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   task automatic results;
      if (mismatches == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      do_reset;
      rc("label", 8'h6C, 32'h0);
      rc("select", 8'h70, 32'h0);
      wr(8'h6C, 32'hA5A5_5A5A);
      chk("bresp", RESP_OKAY, b);
      rc("label", 8'h6C, 32'hA5A5_5A5A);
      wr(8'h70, 32'hFFFF_1234);
      rc("select", 8'h70, 32'h0000_1234);
      for (int i = 0; i < 5; i++) begin
         v = vals[i];
         e = (v > port_total) ? 8'hFF : v;
         idx = {8'(i), 8'hA5};
         wr(8'h70, {16'h0, idx});
         wr(8'h74, {24'h0, v});
         rc("egress", 8'h74, {24'h0, e});
         rc("select", 8'h70, {16'h0, idx});
         lookup_id <= {8{idx}};
         repeat (2) @(posedge aclk);
         chk("lookup", {8{e}}, lookup_egress);
      end
      clk_en <= 1'b0;
      lookup_id <= {8{16'h01A5}};
      repeat (3) @(posedge aclk);
      chk("frozen", {8{8'hFF}}, lookup_egress);
      clk_en <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("lookup", {8{8'h07}}, lookup_egress);
      wr(8'h70, 32'h0000_00A5);
      rc("egress", 8'h74, 32'h3);
      chk("label_out", 64'hA5A5_5A5A, component_label_value);
      rd(8'h78, d);
      chk("unmapped_rd", {RESP_SLVERR, 32'h0}, {r, d});
      wr(8'h78, 32'hFFFF_FFFF);
      chk("unmapped_wr", RESP_SLVERR, b);
      rc("label", 8'h6C, 32'hA5A5_5A5A);
      do_reset;
      rc("label", 8'h6C, 32'h0);
      rc("select", 8'h70, 32'h0);
      results;
   end

   // Watchdog
   initial begin
      repeat (5000) @(posedge aclk);
      mismatches++;
      results;
   end
endmodule
